// >>> hdl/rf_synth_divider_control.sv
/*
  RF half of a dual synthesizer: three-wire serial word capture, reference
  and feedback word registers, reference divider, dual-modulus feedback
  divider and powerdown sequencing.
  Assumes every pin input is asynchronous to CLOCK and that the serial
  clock and the divider inputs run well below half the CLOCK rate.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rf_synth_regs.svh"

module rf_synth_divider_control
  import rf_synth_pkg::*;
#(
  parameter bit HIGHEST_BAND = 1'b1
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  input wire logic LATCH_ENABLE,
  input wire logic REF_IN,
  input wire logic VCO_IN,
  output logic REF_DIV_OUT,
  output logic FB_DIV_OUT,
  output logic DETECTOR_POLARITY,
  output logic PUMP_GAIN_HIGH,
  output logic PUMP_HIGH_Z,
  output logic RF_SLEEP,
  output logic SLEEP_ASYNC,
  output logic [1:0] MULTI_OUTPUT_SELECT
);

  // Small prescaler modulus for the given select and variant
  function automatic logic [7:0] fb_modulus(input logic sel, input logic top_variant);
    if (top_variant) begin
      fb_modulus = sel ? `MOD_64 : `MOD_32;
    end else begin
      fb_modulus = sel ? `MOD_128 : `MOD_64;
    end
  endfunction

  logic rst_meta_q;
  logic rst_n;
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic [4:0] prev_q;
  logic ser_clk_rise;
  logic latch_rise;
  logic ref_rise;
  logic vco_rise;
  logic [21:0] shift_q;
  ref_word_type ref_word_q;
  fb_word_type fb_word_q;
  logic [14:0] ref_cnt_q;
  logic [7:0] pre_cnt_q;
  logic [10:0] main_cnt_q;
  logic [7:0] modulus;
  logic swallow_phase;
  logic [7:0] pre_top;
  logic awake;
  power_state_type pwr_q;
  power_state_type pwr_d;

  // Reset release through two flops so removal is clean
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Pin synchronisers; edge detectors compare the second and third stages
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 5'h00;
      sync_q <= 5'h00;
      prev_q <= 5'h00;
    end else begin
      meta_q <= {SER_CLK, SER_DATA, LATCH_ENABLE, REF_IN, VCO_IN};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign ser_clk_rise = sync_q[4] & ~prev_q[4];
  assign latch_rise = sync_q[2] & ~prev_q[2];
  assign ref_rise = sync_q[1] & ~prev_q[1];
  assign vco_rise = sync_q[0] & ~prev_q[0];

  // Serial shift, MSB first; data is aligned with the clock sample
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 22'h000000;
    end else if (ser_clk_rise) begin
      shift_q <= {shift_q[20:0], sync_q[3]};
    end
  end

  // Latch into the register named by the address field only
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ref_word_q <= ref_word_type'(`REF_WORD_RESET);
      fb_word_q <= fb_word_type'(`FB_WORD_RESET);
    end else if (latch_rise) begin
      if (shift_q[1:0] == `ADDR_REFERENCE) begin
        ref_word_q <= ref_word_type'(shift_q);
      end else if (shift_q[1:0] == `ADDR_FEEDBACK) begin
        fb_word_q <= fb_word_type'(shift_q);
      end
    end
  end

  // Loop settings go out straight from the latched word, no divider wait
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      DETECTOR_POLARITY <= 1'b0;
      PUMP_GAIN_HIGH <= 1'b0;
      PUMP_HIGH_Z <= 1'b0;
      MULTI_OUTPUT_SELECT <= 2'h0;
      SLEEP_ASYNC <= 1'b0;
    end else begin
      DETECTOR_POLARITY <= ref_word_q.rf_detector_polarity;
      PUMP_GAIN_HIGH <= ref_word_q.rf_pump_gain_select;
      PUMP_HIGH_Z <= ref_word_q.rf_pump_high_z;
      MULTI_OUTPUT_SELECT <= ref_word_q.multi_output_select;
      SLEEP_ASYNC <= ref_word_q.rf_pump_high_z & fb_word_q.rf_sleep_request;
    end
  end

  // Powerdown: async mode sleeps at once, sync mode waits for a ref tick
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      PWR_ACTIVE: begin
        if (fb_word_q.rf_sleep_request) begin
          pwr_d = ref_word_q.rf_pump_high_z ? PWR_ASLEEP : PWR_PENDING;
        end
      end
      PWR_PENDING: begin
        if (!fb_word_q.rf_sleep_request) begin
          pwr_d = PWR_ACTIVE;
        end else if (ref_word_q.rf_pump_high_z || REF_DIV_OUT) begin
          pwr_d = PWR_ASLEEP;
        end
      end
      default: begin
        if (!fb_word_q.rf_sleep_request) begin
          pwr_d = PWR_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= PWR_ACTIVE;
      RF_SLEEP <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      RF_SLEEP <= (pwr_d == PWR_ASLEEP);
    end
  end

  assign awake = (pwr_q != PWR_ASLEEP);

  // Reference divider; ratios under three are not supported
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_q <= 15'h0000;
      REF_DIV_OUT <= 1'b0;
    end else if (!awake) begin
      ref_cnt_q <= 15'h0000;
      REF_DIV_OUT <= 1'b0;
    end else begin
      REF_DIV_OUT <= 1'b0;
      if (ref_rise) begin
        // Compare with >= so a smaller new ratio cannot run away
        if (ref_cnt_q >= ref_word_q.rf_reference_ratio - 15'h0001) begin
          ref_cnt_q <= 15'h0000;
          REF_DIV_OUT <= 1'b1;
        end else begin
          ref_cnt_q <= ref_cnt_q + 15'h0001;
        end
      end
    end
  end

  // Prescaler runs at modulus plus one while swallow cycles remain
  assign modulus = fb_modulus(fb_word_q.rf_prescaler_select, HIGHEST_BAND);
  assign swallow_phase = {4'h0, fb_word_q.rf_swallow_count} > main_cnt_q;
  assign pre_top = swallow_phase ? modulus : modulus - 8'h01;

  // Feedback divider: total is modulus times main plus swallow
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_q <= 8'h00;
      main_cnt_q <= 11'h000;
      FB_DIV_OUT <= 1'b0;
    end else if (!awake) begin
      pre_cnt_q <= 8'h00;
      main_cnt_q <= 11'h000;
      FB_DIV_OUT <= 1'b0;
    end else begin
      FB_DIV_OUT <= 1'b0;
      if (vco_rise) begin
        if (pre_cnt_q >= pre_top) begin
          pre_cnt_q <= 8'h00;
          if (main_cnt_q >= fb_word_q.rf_main_count - 11'h001) begin
            main_cnt_q <= 11'h000;
            FB_DIV_OUT <= 1'b1;
          end else begin
            main_cnt_q <= main_cnt_q + 11'h001;
          end
        end else begin
          pre_cnt_q <= pre_cnt_q + 8'h01;
        end
      end
    end
  end

  AST_REF_LOAD: assert property (@(posedge CLOCK) disable iff (!rst_n)
    latch_rise && shift_q[1:0] == `ADDR_REFERENCE |=> ref_word_q == $past(shift_q))
    else $error("reference word not loaded");

  AST_FB_LOAD: assert property (@(posedge CLOCK) disable iff (!rst_n)
    latch_rise && shift_q[1:0] == `ADDR_FEEDBACK
    |=> fb_word_q.rf_main_count == $past(shift_q[19:9])
        && fb_word_q.rf_swallow_count == $past(shift_q[8:2]))
    else $error("feedback counts not loaded");

  AST_OTHER_HELD: assert property (@(posedge CLOCK) disable iff (!rst_n)
    latch_rise && !shift_q[1] |=> $stable(ref_word_q) && $stable(fb_word_q))
    else $error("unaddressed word changed a register");

  AST_HIGHZ_FAST: assert property (@(posedge CLOCK) disable iff (!rst_n)
    latch_rise && shift_q[1:0] == `ADDR_REFERENCE
    |-> ##2 PUMP_HIGH_Z == $past(shift_q[`REF_HIGH_Z_BIT], 2))
    else $error("pump high impedance late");

  AST_REF_TICK: assert property (@(posedge CLOCK) disable iff (!rst_n)
    awake && ref_rise && ref_cnt_q == ref_word_q.rf_reference_ratio - 15'h0001
    && !$changed(ref_word_q) |=> REF_DIV_OUT && ref_cnt_q == 15'h0000)
    else $error("reference divider missed its count");

  AST_SWALLOW_MOD: assert property (@(posedge CLOCK) disable iff (!rst_n)
    awake && vco_rise && swallow_phase && pre_cnt_q == modulus - 8'h01
    && $stable(fb_word_q) |=> pre_cnt_q == modulus)
    else $error("prescaler did not stretch in swallow phase");

  AST_SLEEP_ASYNC: assert property (@(posedge CLOCK) disable iff (!rst_n)
    pwr_q == PWR_ACTIVE && fb_word_q.rf_sleep_request && ref_word_q.rf_pump_high_z
    |=> RF_SLEEP ##1 (REF_DIV_OUT == 1'b0 && FB_DIV_OUT == 1'b0))
    else $error("async powerdown not immediate");

  AST_SLEEP_SYNC: assert property (@(posedge CLOCK) disable iff (!rst_n)
    pwr_q == PWR_PENDING && !REF_DIV_OUT && !ref_word_q.rf_pump_high_z |=> !RF_SLEEP)
    else $error("sync powerdown did not wait for reference tick");

endmodule
`default_nettype wire

// >>> hdl/rf_synth_regs.svh
/*
  Constants of the RF synthesizer control block: word addresses, field
  positions, reset values and prescaler moduli.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef RF_SYNTH_REGS_SVH
`define RF_SYNTH_REGS_SVH

// Serial word geometry
`define WORD_WIDTH 22
`define ADDR_REFERENCE 2'h2
`define ADDR_FEEDBACK 2'h3

// Reference word field positions
`define REF_RATIO_LSB 2
`define REF_RATIO_MSB 16
`define REF_POLARITY_BIT 17
`define REF_GAIN_BIT 18
`define REF_HIGH_Z_BIT 19
`define REF_MULTI_LSB 20

// Feedback word field positions
`define FB_SWALLOW_LSB 2
`define FB_MAIN_LSB 9
`define FB_PRESCALER_BIT 20
`define FB_SLEEP_BIT 21

// Reset words: ratio 3, main count 3, swallow 0, loop active
`define REF_WORD_RESET 22'h00000E
`define FB_WORD_RESET 22'h000603

// Prescaler base moduli; the large modulus is one more
`define MOD_32 8'h20
`define MOD_64 8'h40
`define MOD_128 8'h80

`endif

// >>> hdl/rf_synth_pkg.sv
/*
  Types of the RF synthesizer control block: the two serial words as
  packed structs and the power state enumeration.
  Assumes rf_synth_regs.svh is on the include path.
*/
`default_nettype none
`include "rf_synth_regs.svh"

package rf_synth_pkg;

  // Reference word, bit 21 down to bit 0
  typedef struct packed {
    logic [1:0] multi_output_select;
    logic rf_pump_high_z;
    logic rf_pump_gain_select;
    logic rf_detector_polarity;
    logic [14:0] rf_reference_ratio;
    logic [1:0] addr;
  } ref_word_type;

  // Feedback word, bit 21 down to bit 0
  typedef struct packed {
    logic rf_sleep_request;
    logic rf_prescaler_select;
    logic [10:0] rf_main_count;
    logic [6:0] rf_swallow_count;
    logic [1:0] addr;
  } fb_word_type;

  typedef enum logic [1:0] {PWR_ACTIVE, PWR_PENDING, PWR_ASLEEP} power_state_type;

endpackage
`default_nettype wire

// >>> tb/host_link.sv
/*
  Host model of the three-wire link: shifts 22-bit words MSB first and
  pulses the latch.
  Assumes the bench's system clock paces it; 8 clocks make one link period.
*/
`timescale 1ns/10ps
`default_nettype none
module host_link (
  input wire logic clock,
  output logic ser_clk,
  output logic ser_data,
  output logic latch_enable
);
  // Link clock stands still low between frames
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_enable = 1'b0;
  end

  // Moves land 2 ns after a clock edge
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  // Data settles a half period before each rise, held through it
  task automatic send(input logic [21:0] w);
    hold(1);
    for (int i = 21; i >= 0; i--) begin
      ser_data = w[i];
      hold(4);
      ser_clk = 1'b1;
      hold(4);
      ser_clk = 1'b0;
    end
    // Line flips to the inverse of the last bit, so no stale bit shows
    ser_data = ~w[0];
    hold(4);
    latch_enable = 1'b1;
    hold(4);
    latch_enable = 1'b0;
    hold(8);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_rf_synth_divider_control.sv
/*
  Self-checking bench: words over the link, divider pulse counts, levels.
  Assumes the package and host_link are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_rf_synth_divider_control
  import rf_synth_pkg::*;
;
  typedef struct {string name; logic [15:0] val;} note_type;
  note_type notes[$];
  event chk_ev;
  logic clock, rst_n, ref_in, vco_in, ser_clk, ser_data, latch_enable;
  logic ref_div_out, fb_div_out, pol, gain, high_z, sleep, sleep_async;
  logic [1:0] multi;
  logic fb_low;
  int n_low = 0;
  int errors = 0;
  int checked = 0;
  int n_ref = 0;
  int n_fb = 0;
  ref_word_type rw;
  fb_word_type fw;

  rf_synth_divider_control i_rf_synth_divider_control (.CLOCK(clock), .RST_N(rst_n),
    .SER_CLK(ser_clk), .SER_DATA(ser_data), .LATCH_ENABLE(latch_enable), .REF_IN(ref_in),
    .VCO_IN(vco_in), .REF_DIV_OUT(ref_div_out), .FB_DIV_OUT(fb_div_out),
    .DETECTOR_POLARITY(pol), .PUMP_GAIN_HIGH(gain), .PUMP_HIGH_Z(high_z),
    .RF_SLEEP(sleep), .SLEEP_ASYNC(sleep_async), .MULTI_OUTPUT_SELECT(multi));
  // Lower band variant on the same pins; only its feedback count is watched
  rf_synth_divider_control #(.HIGHEST_BAND(1'b0)) i_rf_synth_divider_control_low (
    .CLOCK(clock), .RST_N(rst_n), .SER_CLK(ser_clk), .SER_DATA(ser_data),
    .LATCH_ENABLE(latch_enable), .REF_IN(ref_in), .VCO_IN(vco_in), .REF_DIV_OUT(),
    .FB_DIV_OUT(fb_low), .DETECTOR_POLARITY(), .PUMP_GAIN_HIGH(), .PUMP_HIGH_Z(),
    .RF_SLEEP(), .SLEEP_ASYNC(), .MULTI_OUTPUT_SELECT());
  host_link i_host_link (.clock(clock), .ser_clk(ser_clk), .ser_data(ser_data),
    .latch_enable(latch_enable));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Divider pulses last one clock, so count each sampled high
  always @(posedge clock) begin
    if (ref_div_out === 1'b1) n_ref++;
    if (fb_div_out === 1'b1) n_fb++;
    if (fb_low === 1'b1) n_low++;
  end

  task automatic note(input string nm, input logic [15:0] v);
    notes.push_back('{nm, v});
    -> chk_ev;
  endtask

  // Watcher: oldest note against what the outputs show now
  initial begin
    note_type n;
    logic [15:0] seen;
    forever begin
      @(chk_ev);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        seen = {9'h000, multi, sleep_async, sleep, high_z, gain, pol};
        if (n.name == "pulses") seen = {n_ref[7:0], n_fb[7:0]};
        if (n.name == "low_band") seen = n_low[15:0];
        checked++;
        if (seen !== n.val) begin
          errors++;
          $display("BAD %s expected %h seen %h", n.name, n.val, seen);
        end
      end
    end
  end

  task automatic wr_ref(input logic [1:0] m, input logic hz, g, p, input logic [14:0] r);
    rw = '{m, hz, g, p, r, 2'h2};
    i_host_link.send(rw);
    n_ref = 0;
    n_fb = 0;
  endtask

  task automatic wr_fb(input logic s, pre, input logic [10:0] mn, input logic [6:0] sw);
    fw = '{s, pre, mn, sw, 2'h3};
    i_host_link.send(fw);
    n_ref = 0;
    n_fb = 0;
    n_low = 0;
  endtask

  // Edge period of 8 clocks stays well inside what the sync can count
  task automatic pulse(input int n, input bit fb);
    repeat (n) begin
      @(posedge clock);
      #2;
      if (fb) vco_in = 1'b1;
      else ref_in = 1'b1;
      repeat (4) @(posedge clock);
      #2;
      vco_in = 1'b0;
      ref_in = 1'b0;
      repeat (3) @(posedge clock);
    end
    repeat (8) @(posedge clock);
    #2;
  endtask

  task automatic tally_and_finish;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    logic [1:0] m;
    logic hz, g, p;
    logic [14:0] r;
    ref_in = 1'b0;
    vco_in = 1'b0;
    rst_n = 1'b0;
    void'($urandom(42892));
    repeat (10) @(posedge clock);
    #2;
    rst_n = 1'b1;
    repeat (6) @(posedge clock);
    #2;
    note("levels", 16'h0000);
    // Whole divider periods only, so every count restarts from zero
    for (int k = 0; k < 4; k++) begin
      {m, hz, g, p} = 5'($urandom);
      r = (k == 0) ? 15'h0003 : 15'(3 + $urandom % 6);
      wr_ref(m, hz, g, p, r);
      note("levels", {9'h000, m, 2'b00, hz, g, p});
      pulse(3 * r, 1'b0);
      note("pulses", 16'h0300);
    end
    for (int a = 0; a < 2; a++) i_host_link.send({20'hFFFFF, 2'(a)});
    note("levels", {9'h000, m, 2'b00, hz, g, p});
    wr_ref(2'b00, 1'b0, 1'b0, 1'b0, 15'h0003);
    for (int s = 0; s < 2; s++) begin
      wr_fb(1'b0, s[0], 11'h003, 7'h02);
      pulse(2 * ((s == 1 ? 64 : 32) * 3 + 2), 1'b1);
      note("pulses", 16'h0002);
      // Lower band period 194 then 386 edges: one tick each, leftover carried
      note("low_band", 16'h0001);
    end
    note("levels", 16'h0000);
    // Synchronous powerdown waits for a reference tick
    wr_fb(1'b1, 1'b0, 11'h003, 7'h00);
    note("levels", 16'h0000);
    pulse(3, 1'b0);
    note("levels", 16'h0008);
    n_ref = 0;
    pulse(6, 1'b0);
    pulse(6, 1'b1);
    note("pulses", 16'h0000);
    wr_fb(1'b0, 1'b0, 11'h003, 7'h00);
    note("levels", 16'h0000);
    wr_ref(2'b00, 1'b1, 1'b0, 1'b0, 15'h0003);
    note("levels", 16'h0004);
    wr_fb(1'b1, 1'b0, 11'h003, 7'h00);
    note("levels", 16'h001C);
    repeat (2) @(posedge clock);
    tally_and_finish;
  end

  // Watchdog well past the roughly 0.4 ms that the tests need
  initial begin
    #3000000;
    errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
